// *** hdl/scmd_decoder.sv ***
// Configuration-mode image decoder of a fieldbus stepper indexer
`timescale 1ns/1ps

// Functional notes
// [RULE_01] Image is ten 16-bit words each way, out and in.
// [RULE_02] Control word bit 15 high selects configuration mode, low command mode.
// [RULE_03] Powers up in command mode reporting 6408h unless flash holds a valid setup.
// [RULE_04] No motor power and no moves until a valid configuration exists.
// [RULE_05] Host-written configuration is volatile unless a save is commanded.
// [RULE_06] A saved valid configuration is applied at every power up; host may overwrite; the code ignores host images after a save until reset.
// [RULE_07] Large values travel as thousands word then remainder word, same sign.
// [RULE_08] Words 2 and 3 give start speed, 1 to 1,999,999 steps per second.
// [RULE_09] Steps 200..32767, idle percent 0..100, run current 10..34 tenths.
// [RULE_10] Stall detection needs encoder enabled and 1024 counts; words 5, 9 zero.
// [RULE_11] Control bit 14 zero enables anti-resonance, one disables it.
// [RULE_12] Control bit 11 one makes homing use the home proximity indication.
// [RULE_13] Control bit 10 one enables the quadrature encoder.
// [RULE_14] Host writes zero to every reserved control bit.
// [RULE_15] Control bits 5-3 code input 2, bits 2-0 code input 1.
// [RULE_16] Code 0 general purpose, 1 clockwise limit, 2 counter-clockwise limit.
// [RULE_17] Code 3 starts indexed move on activation; captures encoder on each edge.
// [RULE_18] Code 4 stops jog or registration move, capturing encoder when enabled.
// [RULE_19] Code 5 is emergency stop on inactive-to-active transition.
// [RULE_20] Code 6 is the home input; code 7 is reserved.
// [RULE_21] Reject reserved bits, out-of-range values, duplicate functions, lone stall, code 7.
// [RULE_22] Input word 0 echoes control word when accepted, else command status.
// [RULE_23] Commands act only on a zero-to-one bit transition, also across mode switch.
// [RULE_24] Each new image in configuration mode is rechecked before latching.
// [RULE_25] Reset clears settings unless a valid image is restored from flash.
module scmd_decoder
  import scmd_pkg::*;
#(
  parameter int WORD_W  = SCMD_WORD_W,
  parameter int N_WORDS = SCMD_NUM_WORDS
)(
  input  wire logic                             mclk,
  input  wire logic                             arst_n,
  input  wire logic                             out_img_strobe,
  input  wire logic [N_WORDS-1:0][WORD_W-1:0]   out_img,
  output logic      [N_WORDS-1:0][WORD_W-1:0]   in_img,
  input  wire logic [N_WORDS-1:0][WORD_W-1:0]   cmd_resp,
  input  wire logic                             nv_cfg_present,
  input  wire logic [N_WORDS-1:0][WORD_W-1:0]   nv_cfg_img,
  output logic                                  nv_save_req,
  output logic      [N_WORDS-1:0][WORD_W-1:0]   nv_save_img,
  input  wire logic                             nv_save_done,
  input  wire logic                             nv_save_ok,
  input  wire logic                             in1_pin,
  input  wire logic                             in2_pin,
  output logic                                  configured,
  output logic                                  cfg_mode,
  output logic                                  motor_power_en,
  output logic                                  anti_resonance_disable,
  output logic                                  stall_detect_enable,
  output logic                                  home_proximity_enable,
  output logic                                  encoder_enable,
  output logic      [20:0]                      start_speed,
  output logic      [WORD_W-1:0]                steps_per_turn,
  output logic      [WORD_W-1:0]                idle_current_percent,
  output logic      [WORD_W-1:0]                run_current_tenths,
  output logic      [2*WORD_W-1:0]              cmd_rise,
  output logic                                  cw_limit,
  output logic                                  ccw_limit,
  output logic                                  home_input,
  output logic      [1:0]                       gp_inputs,
  output logic                                  index_start,
  output logic                                  jog_stop,
  output logic                                  estop,
  output logic                                  enc_capture
);

  // ==========================================================================
  // Elaboration check
  generate
    if (WORD_W != SCMD_WORD_W || N_WORDS != SCMD_NUM_WORDS)
    begin : g_bad_geometry
      $error("scmd_decoder serves only a ten-word image of 16-bit words");
    end
  endgenerate

  typedef logic [N_WORDS-1:0][WORD_W-1:0] scmd_img_type;

  typedef struct packed {
    scmd_state_type                  state;
    scmd_img_type                    cfg;
    logic                            cfg_mode;
    logic [2*WORD_W-1:0]             cmd_prev;
    logic                            save_prev;
    logic [1:0]                      act_prev;
    scmd_img_type                    in_img;
    logic                            save_req;
    scmd_img_type                    save_img;
    logic [2*WORD_W-1:0]             cmd_rise;
    logic [20:0]                     speed;
    logic [1:0]                      gp;
    logic                            cw;
    logic                            ccw;
    logic                            home;
    logic                            index_start;
    logic                            jog_stop;
    logic                            estop;
    logic                            enc_capture;
  } scmd_regs_type;

  scmd_regs_type r_q;
  scmd_regs_type r_d;

  // ==========================================================================
  // Image check
  function automatic logic img_valid(input scmd_img_type img);
    logic [15:0] ctrl;
    logic [15:0] setup;
    logic [2:0]  f1;
    logic [2:0]  f2;
    logic        ok;
    ctrl  = img[SCMD_W_CTRL];
    setup = img[SCMD_W_SETUP];
    f1    = ctrl[SCMD_CTRL_IN1_LSB +: 3];
    f2    = ctrl[SCMD_CTRL_IN2_LSB +: 3];
    ok    = 1'b1;
    if ((ctrl & SCMD_CTRL_RSVD_MASK) != 16'h0000)                                    // RULE_21
      ok = 1'b0;
    if ((setup & SCMD_SETUP_RSVD_MASK) != 16'h0000)                                  // RULE_21
      ok = 1'b0;
    if (f1 == SCMD_IN_RSVD || f2 == SCMD_IN_RSVD)                                    // RULE_20
      ok = 1'b0;
    if (f1 == f2 && f1 != SCMD_IN_GP)                                                // RULE_21
      ok = 1'b0;
    // Both speed words must be non-negative, low word below one thousand
    if (img[SCMD_W_SPEED_HI] > SCMD_SPEED_HI_MAX || img[SCMD_W_SPEED_LO] > SCMD_SPEED_LO_MAX) // RULE_07
      ok = 1'b0;
    if (img[SCMD_W_SPEED_HI] == 16'h0000 && img[SCMD_W_SPEED_LO] == 16'h0000)        // RULE_08
      ok = 1'b0;
    if (img[SCMD_W_STEPS] < SCMD_STEPS_MIN || img[SCMD_W_STEPS] > SCMD_STEPS_MAX)    // RULE_09
      ok = 1'b0;
    if (img[SCMD_W_IDLE] > SCMD_IDLE_MAX)                                            // RULE_09
      ok = 1'b0;
    if (img[SCMD_W_RUN] < SCMD_RUN_MIN || img[SCMD_W_RUN] > SCMD_RUN_MAX)            // RULE_09
      ok = 1'b0;
    if (img[SCMD_W_SPARE_A] != 16'h0000 || img[SCMD_W_SPARE_B] != 16'h0000)          // RULE_10
      ok = 1'b0;
    if (ctrl[SCMD_CTRL_STALL_BIT] &&
        (!ctrl[SCMD_CTRL_QUAD_BIT] || img[SCMD_W_ENC_CPT] != SCMD_ENC_CPT_REQ))      // RULE_10
      ok = 1'b0;
    return ok;
  endfunction

  // Combined start speed from thousands and remainder words
  function automatic logic [20:0] speed_of(input scmd_img_type img);
    logic [20:0] hi;
    hi = 21'(img[SCMD_W_SPEED_HI][10:0]) * SCMD_SPEED_SCALE;                         // RULE_07
    return hi + 21'(img[SCMD_W_SPEED_LO][9:0]);                                      // RULE_08
  endfunction

  // Function code of one input taken from the control word
  function automatic scmd_in_func_type func_of(input logic [15:0] ctrl, input int idx);
    logic [2:0] code;
    code = (idx == 0) ? ctrl[SCMD_CTRL_IN1_LSB +: 3] : ctrl[SCMD_CTRL_IN2_LSB +: 3];  // RULE_15
    return scmd_in_func_type'(code);
  endfunction

  // ==========================================================================
  // Next-state logic
  logic         is_cfg;
  logic         new_valid;
  logic         have_cfg;
  logic [15:0]  cur_ctrl;
  logic [15:0]  cur_setup;
  logic [1:0]   pins;

  always_comb
  begin
    r_d         = r_q;
    pins        = {in2_pin, in1_pin};
    is_cfg      = out_img[SCMD_W_CTRL][SCMD_CTRL_MODE_BIT];                          // RULE_02
    new_valid   = img_valid(out_img);
    have_cfg    = (r_q.state == SCMD_ST_READY) || (r_q.state == SCMD_ST_SAVING) ||
                  (r_q.state == SCMD_ST_LOCKED);
    cur_ctrl    = r_q.cfg[SCMD_W_CTRL];
    cur_setup   = r_q.cfg[SCMD_W_SETUP];
    r_d.save_req    = 1'b0;
    r_d.cmd_rise    = '0;
    r_d.index_start = 1'b0;
    r_d.jog_stop    = 1'b0;
    r_d.estop       = 1'b0;
    r_d.enc_capture = 1'b0;

    // Controller
    case (r_q.state)
      SCMD_ST_BOOT:
      begin
        if (nv_cfg_present && img_valid(nv_cfg_img))                                 // RULE_06
        begin
          r_d.cfg   = nv_cfg_img;
          r_d.speed = speed_of(nv_cfg_img);
          r_d.state = SCMD_ST_READY;
        end
        else
        begin
          r_d.state = SCMD_ST_UNCFG;                                                 // RULE_25
        end
      end
      SCMD_ST_UNCFG, SCMD_ST_READY:
      begin
        if (out_img_strobe && is_cfg && new_valid &&
            !out_img[SCMD_W_SETUP][SCMD_SETUP_RDCFG_BIT])                            // RULE_24
        begin
          r_d.cfg   = out_img;                                                       // RULE_05
          r_d.speed = speed_of(out_img);
          r_d.state = SCMD_ST_READY;
          if (out_img[SCMD_W_SETUP][SCMD_SETUP_SAVE_BIT] && !r_q.save_prev)
          begin
            r_d.save_req = 1'b1;                                                     // RULE_05
            r_d.save_img = out_img;
            r_d.state    = SCMD_ST_SAVING;
          end
        end
      end
      SCMD_ST_SAVING:
      begin
        if (nv_save_done)
          r_d.state = SCMD_ST_LOCKED;
      end
      SCMD_ST_LOCKED:
      begin
        r_d.state = SCMD_ST_LOCKED;
      end
      default:
      begin
        r_d.state = SCMD_ST_UNCFG;
      end
    endcase

    // Edge history follows every update so held bits never fire later
    if (out_img_strobe)
    begin
      r_d.cfg_mode  = is_cfg;
      r_d.cmd_prev  = {out_img[SCMD_W_CTRL], out_img[SCMD_W_SETUP]};                 // RULE_23
      r_d.save_prev = out_img[SCMD_W_SETUP][SCMD_SETUP_SAVE_BIT];
      if (!is_cfg && have_cfg && r_q.state != SCMD_ST_LOCKED)
        r_d.cmd_rise = {out_img[SCMD_W_CTRL], out_img[SCMD_W_SETUP]} & ~r_q.cmd_prev; // RULE_04 RULE_23
    end

    // Returned image
    if (r_q.cfg_mode)
    begin
      r_d.in_img = r_q.cfg;                                                          // RULE_01
      r_d.in_img[SCMD_W_SPARE_A] = SCMD_WORD_RESET;
      r_d.in_img[SCMD_W_SPARE_B] = SCMD_WORD_RESET;
      if (!have_cfg)
        r_d.in_img[SCMD_W_CTRL] = SCMD_CFG_ERR_STATUS;                               // RULE_22
    end
    else
    begin
      r_d.in_img = cmd_resp;
      if (!have_cfg)
        r_d.in_img[SCMD_W_CTRL] = SCMD_CFG_ERR_STATUS;                               // RULE_03
    end
    if (r_q.state == SCMD_ST_SAVING || r_q.state == SCMD_ST_LOCKED)
      r_d.in_img[SCMD_W_SPARE_B] = r_q.in_img[SCMD_W_SPARE_B];
    if (r_q.state == SCMD_ST_SAVING && nv_save_done)
      r_d.in_img[SCMD_W_SPARE_B] = nv_save_ok ? SCMD_SAVE_OK : SCMD_SAVE_FAIL;

    // Input function mapping
    r_d.gp   = 2'b00;
    r_d.cw   = 1'b0;
    r_d.ccw  = 1'b0;
    r_d.home = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      logic act;
      act = pins[i] ~^ cur_setup[SCMD_SETUP_LVL1_BIT + i];
      r_d.act_prev[i] = act;
      r_d.gp[i] = act;                                                               // RULE_16
      if (have_cfg)
      begin
        case (func_of(cur_ctrl, i))
          SCMD_IN_CW:
            r_d.cw = act;                                                            // RULE_16
          SCMD_IN_CCW:
            r_d.ccw = act;                                                           // RULE_16
          SCMD_IN_INDEX:
          begin
            if (act && !r_q.act_prev[i])
              r_d.index_start = 1'b1;                                                // RULE_17
            if (act != r_q.act_prev[i] && cur_ctrl[SCMD_CTRL_QUAD_BIT])
              r_d.enc_capture = 1'b1;                                                // RULE_17
          end
          SCMD_IN_STOP:
          begin
            if (act && !r_q.act_prev[i])
            begin
              r_d.jog_stop = 1'b1;                                                   // RULE_18
              if (cur_ctrl[SCMD_CTRL_QUAD_BIT])
                r_d.enc_capture = 1'b1;                                              // RULE_18
            end
          end
          SCMD_IN_ESTOP:
          begin
            if (act && !r_q.act_prev[i])
              r_d.estop = 1'b1;                                                      // RULE_19
          end
          SCMD_IN_HOME:
            r_d.home = act;                                                          // RULE_20
          default:
          begin
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r_q <= '{state: SCMD_ST_BOOT, default: '0};                                   // RULE_25
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ==========================================================================
  // Outputs
  logic have_q;

  assign have_q                 = (r_q.state == SCMD_ST_READY) || (r_q.state == SCMD_ST_SAVING);
  assign configured             = have_q;
  assign cfg_mode               = r_q.cfg_mode;
  assign motor_power_en         = have_q && r_q.cfg[SCMD_W_SETUP][SCMD_SETUP_DRIVE_BIT];  // RULE_04
  assign anti_resonance_disable = r_q.cfg[SCMD_W_CTRL][SCMD_CTRL_AR_BIT];                 // RULE_11
  assign stall_detect_enable    = r_q.cfg[SCMD_W_CTRL][SCMD_CTRL_STALL_BIT];
  assign home_proximity_enable  = r_q.cfg[SCMD_W_CTRL][SCMD_CTRL_HPROX_BIT];              // RULE_12
  assign encoder_enable         = r_q.cfg[SCMD_W_CTRL][SCMD_CTRL_QUAD_BIT];               // RULE_13
  assign start_speed            = r_q.speed;
  assign steps_per_turn         = r_q.cfg[SCMD_W_STEPS];
  assign idle_current_percent   = r_q.cfg[SCMD_W_IDLE];
  assign run_current_tenths     = r_q.cfg[SCMD_W_RUN];
  assign in_img                 = r_q.in_img;
  assign nv_save_req            = r_q.save_req;
  assign nv_save_img            = r_q.save_img;
  assign cmd_rise               = r_q.cmd_rise;
  assign cw_limit               = r_q.cw;
  assign ccw_limit              = r_q.ccw;
  assign home_input             = r_q.home;
  assign gp_inputs              = r_q.gp;
  assign index_start            = r_q.index_start;
  assign jog_stop               = r_q.jog_stop;
  assign estop                  = r_q.estop;
  assign enc_capture            = r_q.enc_capture;

endmodule

// *** inc/scmd_pkg.sv ***
// Constants and types shared by the stepper configuration-mode decoder
package scmd_pkg;

  // ==========================================================================
  // Image geometry
  localparam int SCMD_NUM_WORDS = 10;
  localparam int SCMD_WORD_W    = 16;

  // ==========================================================================
  // Word indices of the cyclic output image
  localparam int SCMD_W_CTRL     = 0;
  localparam int SCMD_W_SETUP    = 1;
  localparam int SCMD_W_SPEED_HI = 2;
  localparam int SCMD_W_SPEED_LO = 3;
  localparam int SCMD_W_STEPS    = 4;
  localparam int SCMD_W_SPARE_A  = 5;
  localparam int SCMD_W_ENC_CPT  = 6;
  localparam int SCMD_W_IDLE     = 7;
  localparam int SCMD_W_RUN      = 8;
  localparam int SCMD_W_SPARE_B  = 9;

  // ==========================================================================
  // Field positions of mode_and_options_word
  localparam int SCMD_CTRL_MODE_BIT  = 15;
  localparam int SCMD_CTRL_AR_BIT    = 14;
  localparam int SCMD_CTRL_STALL_BIT = 13;
  localparam int SCMD_CTRL_HPROX_BIT = 11;
  localparam int SCMD_CTRL_QUAD_BIT  = 10;
  localparam int SCMD_CTRL_IN2_LSB   = 3;
  localparam int SCMD_CTRL_IN1_LSB   = 0;
  localparam logic [15:0] SCMD_CTRL_RSVD_MASK = 16'h13c0;

  // ==========================================================================
  // Field positions of setup_word
  localparam int SCMD_SETUP_DRIVE_BIT = 15;
  localparam int SCMD_SETUP_RDCFG_BIT = 11;
  localparam int SCMD_SETUP_SAVE_BIT  = 10;
  localparam int SCMD_SETUP_LVL2_BIT  = 1;
  localparam int SCMD_SETUP_LVL1_BIT  = 0;
  localparam logic [15:0] SCMD_SETUP_RSVD_MASK = 16'h73fc;

  // ==========================================================================
  // Parameter ranges
  localparam logic [15:0] SCMD_SPEED_HI_MAX = 16'h07cf;
  localparam logic [15:0] SCMD_SPEED_LO_MAX = 16'h03e7;
  localparam logic [20:0] SCMD_SPEED_SCALE  = 21'h0003e8;
  localparam logic [15:0] SCMD_STEPS_MIN    = 16'h00c8;
  localparam logic [15:0] SCMD_STEPS_MAX    = 16'h7fff;
  localparam logic [15:0] SCMD_ENC_CPT_REQ  = 16'h0400;
  localparam logic [15:0] SCMD_IDLE_MAX     = 16'h0064;
  localparam logic [15:0] SCMD_RUN_MIN      = 16'h000a;
  localparam logic [15:0] SCMD_RUN_MAX      = 16'h0022;

  // ==========================================================================
  // Status values
  localparam logic [15:0] SCMD_CFG_ERR_STATUS = 16'h6408;
  localparam logic [15:0] SCMD_SAVE_OK        = 16'haaaa;
  localparam logic [15:0] SCMD_SAVE_FAIL      = 16'heeee;
  localparam logic [15:0] SCMD_WORD_RESET     = 16'h0000;

  // ==========================================================================
  // Input function codes
  typedef enum logic [2:0] {
    SCMD_IN_GP    = 3'h0,
    SCMD_IN_CW    = 3'h1,
    SCMD_IN_CCW   = 3'h2,
    SCMD_IN_INDEX = 3'h3,
    SCMD_IN_STOP  = 3'h4,
    SCMD_IN_ESTOP = 3'h5,
    SCMD_IN_HOME  = 3'h6,
    SCMD_IN_RSVD  = 3'h7
  } scmd_in_func_type;

  // ==========================================================================
  // Controller states, one-hot
  typedef enum logic [4:0] {
    SCMD_ST_BOOT   = 5'h01,
    SCMD_ST_UNCFG  = 5'h02,
    SCMD_ST_READY  = 5'h04,
    SCMD_ST_SAVING = 5'h08,
    SCMD_ST_LOCKED = 5'h10
  } scmd_state_type;

endpackage

// *** verif/scmd_asserts.sv ***
// Concurrent checks on the ports of the configuration-mode decoder
`timescale 1ns/1ps
module scmd_asserts
  import scmd_pkg::*;
#(
  parameter int WORD_W  = SCMD_WORD_W,
  parameter int N_WORDS = SCMD_NUM_WORDS
)(
  input wire logic                           mclk,
  input wire logic                           arst_n,
  input wire logic                           out_img_strobe,
  input wire logic [N_WORDS-1:0][WORD_W-1:0] out_img,
  input wire logic [N_WORDS-1:0][WORD_W-1:0] in_img,
  input wire logic                           configured,
  input wire logic                           cfg_mode,
  input wire logic                           motor_power_en,
  input wire logic                           stall_detect_enable,
  input wire logic                           encoder_enable,
  input wire logic [20:0]                    start_speed,
  input wire logic [WORD_W-1:0]              steps_per_turn,
  input wire logic [WORD_W-1:0]              idle_current_percent,
  input wire logic [WORD_W-1:0]              run_current_tenths,
  input wire logic [2*WORD_W-1:0]            cmd_rise,
  input wire logic                           estop
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // Image acceptance steps
  sequence s_cfg_take;
    out_img_strobe && out_img[0][15];
  endsequence
  sequence s_first_cfg;
    (out_img_strobe && out_img[0][15] && !configured) ##1 configured;
  endsequence
  AST_MODE_BIT:
    assert property (out_img_strobe |=> cfg_mode == $past(out_img[0][15])) else $error("mode flag wrong");
  AST_POWER_GATE:
    assert property (motor_power_en |-> configured) else $error("motor powered unconfigured");
  AST_NO_CMD_UNCFG:
    assert property ((out_img_strobe && !configured) |=> cmd_rise == '0) else $error("command while unconfigured");
  AST_NO_CMD_IN_CFG:
    assert property (s_cfg_take |=> cmd_rise == '0) else $error("command in configuration mode");
  AST_RSVD_REJECT:
    assert property ((out_img_strobe && (out_img[0] & SCMD_CTRL_RSVD_MASK) != '0 && !configured) |=> !configured)
      else $error("reserved bits accepted");
  AST_SPEED_RANGE:
    assert property (configured |-> start_speed inside {[21'h000001:21'h1e847f]}) else $error("speed out of range");
  AST_PARAM_RANGE:
    assert property (configured |-> steps_per_turn >= 16'h00c8 && idle_current_percent <= 16'h0064
      && run_current_tenths inside {[16'h000a:16'h0022]}) else $error("parameter out of range");
  AST_STALL_ENC:
    assert property ((configured && stall_detect_enable) |-> encoder_enable) else $error("stall without encoder");
  AST_ECHO:
    assert property (s_first_cfg |=> in_img[0] == $past(out_img[0], 2)) else $error("control word not echoed");
  AST_ESTOP_PULSE:
    assert property (estop |=> !estop) else $error("stop pulse too long");
endmodule

bind scmd_decoder scmd_asserts #(.WORD_W(WORD_W), .N_WORDS(N_WORDS)) u_asserts (
  .mclk(mclk), .arst_n(arst_n), .out_img_strobe(out_img_strobe), .out_img(out_img), .in_img(in_img),
  .configured(configured), .cfg_mode(cfg_mode), .motor_power_en(motor_power_en),
  .stall_detect_enable(stall_detect_enable), .encoder_enable(encoder_enable), .start_speed(start_speed),
  .steps_per_turn(steps_per_turn), .idle_current_percent(idle_current_percent),
  .run_current_tenths(run_current_tenths), .cmd_rise(cmd_rise), .estop(estop));

// *** verif/scmd_host.sv ***
// Fieldbus host model that writes cyclic output images
`timescale 1ns/1ps
module scmd_host
  import scmd_pkg::*;
(
  input  wire logic     mclk,
  output logic          strobe,
  output logic [9:0][15:0] img
);
  initial
  begin
    strobe = 1'b0;
    img    = '0;
  end
  // One strobed update; afterwards the words no longer hold their value
  task automatic send(input logic [9:0][15:0] w);
    img    = w;
    strobe = 1'b1;
    @(posedge mclk);
    #1;
    strobe = 1'b0;
    img    = ~w;
  endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the configuration-mode decoder
`timescale 1ns/1ps
module tb_top
  import scmd_pkg::*;
;
  typedef logic [9:0][15:0] scmd_img_type;
  logic         mclk, arst_n, strobe, nvp, nv_done, nv_ok, in1, in2, cfgd, cmode, mpwr, ard, stl, hpx, enc, nv_req;
  logic         cw, ccw, home, idx, jog, est, encc, eb, sb;
  scmd_img_type oimg, iimg, resp, nvimg, nvsave, img, base;
  logic [20:0]  spd;
  logic [15:0]  steps, idle, run, h, l, ctl;
  logic [31:0]  crise;
  logic [1:0]   gp;
  logic [2:0]   c1, c2;
  int           bad_count, cmp_count, seed;
  int           bw [16] = '{0, 5, 9, 4, 7, 8, 8, 0, 0, 0, 0, 3, 2, 2, 1, 1};
  logic [15:0]  bv [16] = '{16'h9000, 16'h0001, 16'h0001, 16'h00c7, 16'h0065, 16'h0009, 16'h0023, 16'h8007,
                            16'h8009, 16'ha000, 16'ha400, 16'h03e8, 16'h07d0, 16'h0000, 16'h8007, 16'h8803};

  scmd_host host (.mclk(mclk), .strobe(strobe), .img(oimg));
  scmd_decoder dut (
    .mclk(mclk), .arst_n(arst_n), .out_img_strobe(strobe), .out_img(oimg), .in_img(iimg), .cmd_resp(resp),
    .nv_cfg_present(nvp), .nv_cfg_img(nvimg), .nv_save_req(nv_req), .nv_save_img(nvsave),
    .nv_save_done(nv_done), .nv_save_ok(nv_ok), .in1_pin(in1), .in2_pin(in2), .configured(cfgd),
    .cfg_mode(cmode), .motor_power_en(mpwr), .anti_resonance_disable(ard), .stall_detect_enable(stl),
    .home_proximity_enable(hpx), .encoder_enable(enc), .start_speed(spd), .steps_per_turn(steps),
    .idle_current_percent(idle), .run_current_tenths(run), .cmd_rise(crise), .cw_limit(cw), .ccw_limit(ccw),
    .home_input(home), .gp_inputs(gp), .index_start(idx), .jog_stop(jog), .estop(est), .enc_capture(encc));

  always #5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic do_reset(input logic p);
    arst_n = 1'b0;
    nvp = p;
    step(12);
    arst_n = 1'b1;
    step(3);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic scmd_img_type mk(input logic [15:0] c, s, hi, lo, st, e, i, r);
    return {16'h0000, r, i, e, 16'h0000, st, lo, hi, s, c};
  endfunction
  function automatic logic [20:0] espd(input logic [15:0] hi, lo);
    return 21'(hi) * 21'h0003e8 + 21'(lo);
  endfunction
  // Expected {cw, ccw, home, index, jog, estop, capture} with encoder on
  function automatic logic [6:0] efx(input logic [2:0] c);
    case (c)
      3'h1: return 7'h40;
      3'h2: return 7'h20;
      3'h3: return 7'h09;
      3'h4: return 7'h05;
      3'h5: return 7'h02;
      3'h6: return 7'h10;
      default: return 7'h00;
    endcase
  endfunction

  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    seed = 6023;
    mclk = 1'b0;
    nv_done = 1'b0;
    nv_ok = 1'b1;
    {in1, in2} = 2'b00;
    resp = {5{$random(seed)}};
    nvimg = mk(16'h8000, 16'h8003, 16'h0000, 16'h0005, 16'h0190, 16'h0000, 16'h0032, 16'h0014);
    do_reset(1'b0);
    chk("status", 32'(iimg[0]), 32'(SCMD_CFG_ERR_STATUS));
    host.send(mk(16'h0001, 16'h0000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0));
    chk("cmd unconfigured", crise, 32'h0);
    base = mk(16'h8000, 16'h8003, 16'h0001, 16'h0000, 16'h00c8, 16'h0000, 16'h0000, 16'h000a);
    for (int k = 0; k < 16; k++)
    begin
      img = base;
      img[bw[k]] = bv[k];
      host.send(img);
      step(1);
      chk("rejected", 32'(cfgd), 32'h0);
      chk("power off", 32'(mpwr), 32'h0);
    end
    for (int k = 0; k < 22; k++)
    begin
      c1 = 3'($unsigned($random(seed)) % 7);
      c2 = 3'($unsigned($random(seed)) % 7);
      if (c1 == c2 && c1 != 3'h0)
        c2 = 3'h0;
      eb = 1'($random(seed));
      sb = eb & 1'($random(seed));
      ctl = {1'b1, 1'($random(seed)), sb, 1'b0, 1'($random(seed)), eb, 4'h0, c2, c1};
      h = (k == 0) ? 16'h07cf : (k == 1) ? 16'h0000 : 16'($unsigned($random(seed)) % 2000);
      l = (k == 0) ? 16'h03e7 : (k == 1) ? 16'h0001 : 16'($unsigned($random(seed)) % 999 + 1);
      img = mk(ctl, 16'h8003, h, l, 16'($unsigned($random(seed)) % 32568 + 200), sb ? 16'h0400 : 16'h0007,
               16'($unsigned($random(seed)) % 101), 16'($unsigned($random(seed)) % 25 + 10));
      host.send(img);
      step(1);
      chk("speed", 32'(spd), 32'(espd(h, l)));
      chk("params", {steps, run}, {img[4], img[8]});
      chk("flags", {ard, stl, hpx, enc, mpwr}, {ctl[14], ctl[13], ctl[11], ctl[10], 1'b1});
      chk("echo", {iimg[0], idle}, {ctl, img[7]});
    end
    for (int c = 0; c < 7; c++)
    begin
      host.send(mk(16'h8400 | 16'(c), 16'h8001, 16'h0001, 16'h0000, 16'h00c8, 16'h0000, 16'h0000, 16'h000a));
      step(1);
      in1 = 1'b1;
      step(1);
      chk("inputs", 32'({cw, ccw, home, idx, jog, est, encc}), 32'(efx(3'(c))));
      chk("active", 32'(gp), 32'h3);
      in1 = 1'b0;
      step(1);
      chk("capture", 32'(encc), 32'(c == 3));
      step(1);
    end
    host.send(mk(16'h0406, 16'h8001, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0));
    chk("held bit", crise, 32'h0);
    step(1);
    host.send(mk(16'h0407, 16'h8001, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0));
    chk("rise", crise, 32'h00010000);
    step(1);
    chk("cmd word", {15'h0, cmode, iimg[0]}, {16'h0, resp[0]});
    host.send(mk(16'h8406, 16'h8401, 16'h0001, 16'h0000, 16'h00c8, 16'h0000, 16'h0000, 16'h000a));
    chk("save req", {nv_req, nvsave[1]}, {1'b1, 16'h8401});
    nv_done = 1'b1;
    step(1);
    nv_done = 1'b0;
    for (int w = 0; w < 4 && iimg[9] !== SCMD_SAVE_OK; w++)
      step(1);
    chk("save status", {iimg[9], 14'h0, cfgd, mpwr}, {SCMD_SAVE_OK, 16'h0});
    do_reset(1'b1);
    chk("restored", {cfgd, steps}, {1'b1, 16'h0190});
    do_reset(1'b0);
    chk("volatile", {cfgd, iimg[0]}, {1'b0, SCMD_CFG_ERR_STATUS});
    tally_and_finish();
  end
endmodule
